//--- rtl/pps_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pps_ctrl
    import pps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    // config space access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic cfg_func,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // pins
    input wire logic host_bus_reset_in_n,
    input wire logic phy_linkon,
    input wire logic phy_int,
    input wire logic ports_idle,
    input wire logic [2:0] card_detect,
    // link controller side, same clock
    input wire logic link_irq,
    // outputs
    output logic host_int,
    output logic pme_n_o,
    output logic pme_oe_n,
    output logic ack_tardy_en,
    output logic link_power_status,
    output logic link_regs_clear,
    output logic link_cfg_clear,
    output logic link_soft_rst,
    output logic phy_doze,
    output logic phy_sleep,
    output logic card_access_en,
    output logic card_soft_rst,
    output logic card_a_clock_out,
    output logic card_b_clock_out
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        pps_pm_t lnk_ps;
        logic lnk_pme_en;
        logic lnk_pme_sts;
        pps_pm_t crd_ps;
        logic crd_pme_en;
        logic crd_pme_sts;
        logic [PPS_PHY_CTL_W-1:0] phy_ctl;
        logic lp_act;
        logic lp_woken;
        logic [2:0] det_q;
        logic lnk_rst;
        logic crd_rst;
        logic lnk_keep;
        logic crd_keep;
        logic int_q;
        logic pme_q;
        logic doze_q;
        logic sleep_q;
        logic cka;
        logic ckb;
        logic [31:0] rdata;
    } pps_st_t;

    pps_st_t st_r;
    pps_st_t st_nxt;

    logic pci_rst_n_s;
    logic linkon_s;
    logic phy_int_s;
    logic ports_idle_s;
    logic [2:0] det_s;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    pps_sync #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_sync_rst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .din(host_bus_reset_in_n),
        .dout(pci_rst_n_s)
    );

    pps_sync #(
        .W(3),
        .RST_VAL(3'h0)
    ) u_sync_phy (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .din({phy_linkon, phy_int, ports_idle}),
        .dout({linkon_s, phy_int_s, ports_idle_s})
    );

    pps_sync #(
        .W(3),
        .RST_VAL(3'h0)
    ) u_sync_det (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .din(card_detect),
        .dout(det_s)
    );

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic wr_lnk_pm;
    logic wr_phy;
    logic wr_crd_pm;
    logic lnk_d0;
    logic lnk_d1;
    logic lnk_d2;
    logic lnk_d3;
    logic lp_state;
    logic force_sel;
    logic sleep_sel;
    logic lp_cond;
    logic det_chg;
    logic lnk_wake;
    logic pci_rst;
    logic keep_lnk_ctx;
    logic keep_crd_ctx;

    assign wr_lnk_pm = cfg_wr && !cfg_func && cfg_addr == PPS_LNK_PMCSR_OFS;
    assign wr_phy = cfg_wr && !cfg_func && cfg_addr == PPS_PHY_LP_OFS;
    assign wr_crd_pm = cfg_wr && cfg_func && cfg_addr == PPS_CRD_PMCSR_OFS;
    assign lnk_d0 = st_r.lnk_ps == PPS_D0;
    assign lnk_d1 = st_r.lnk_ps == PPS_D1;
    assign lnk_d2 = st_r.lnk_ps == PPS_D2;
    // D3cold is D3hot on auxiliary supply; same logic
    assign lnk_d3 = st_r.lnk_ps == PPS_D3;
    assign lp_state = lnk_d2 || lnk_d3;
    assign force_sel = lnk_d2 ? st_r.phy_ctl[PPS_D2_FORCE_BIT]
                              : st_r.phy_ctl[PPS_D3_FORCE_BIT];
    // per-state doze/sleep choice
    assign sleep_sel = lnk_d2 ? st_r.phy_ctl[PPS_D2_SLEEP_BIT]
                              : st_r.phy_ctl[PPS_D3_SLEEP_BIT];
    // idle ports or force bit let the PHY power down
    assign lp_cond = lp_state && (ports_idle_s || force_sel);
    assign det_chg = |(det_s ^ st_r.det_q);
    assign pci_rst = !pci_rst_n_s;
    // pme context survives host bus reset only in D3 with wake armed
    // hold flag carries it on, the state reads D0 after the first reset cycle
    assign keep_lnk_ctx = (lnk_d3 || st_r.lnk_keep) && st_r.lnk_pme_en;
    assign keep_crd_ctx = (st_r.crd_ps == PPS_D3 || st_r.crd_keep) && st_r.crd_pme_en;

    // wake sources per state; forced low power blocks LinkOn wake
    always_comb begin
        lnk_wake = 1'b0;
        unique case (st_r.lnk_ps)
            PPS_D0: begin
                lnk_wake = 1'b0;
            end
            PPS_D1: begin
                lnk_wake = link_irq;
            end
            PPS_D2: begin
                lnk_wake = (linkon_s || phy_int_s) && !(st_r.lp_act && force_sel);
            end
            PPS_D3: begin
                lnk_wake = linkon_s && !(st_r.lp_act && force_sel);
            end
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.lnk_rst = 1'b0;
        st_nxt.crd_rst = 1'b0;
        st_nxt.det_q = det_s;

        // ----------------------------------------
        // link power-management control/status
        // ----------------------------------------
        if (wr_lnk_pm) begin
            // any write to the state field moves the function to the written state
            st_nxt.lnk_ps = pps_pm_t'(cfg_wdata[PPS_PS_LSB +: 2]);
            st_nxt.lnk_pme_en = cfg_wdata[PPS_PME_EN_BIT];
            if (cfg_wdata[PPS_PME_STS_BIT]) begin
                st_nxt.lnk_pme_sts = 1'b0;
            end
            // leaving D3 for D0 resets the link controller on its own
            st_nxt.lnk_rst = lnk_d3 && cfg_wdata[PPS_PS_LSB +: 2] == PPS_D0;
            st_nxt.lp_act = 1'b0;
            st_nxt.lp_woken = 1'b0;
        end
        // set beats a same-cycle write-one clear
        if (lnk_wake) begin
            st_nxt.lnk_pme_sts = 1'b1;
        end

        // ----------------------------------------
        // phy low power entry and LinkOn resume
        // ----------------------------------------
        if (wr_phy) begin
            st_nxt.phy_ctl = cfg_wdata[PPS_PHY_CTL_W-1:0];
        end
        if (!wr_lnk_pm) begin
            if (!lp_state) begin
                st_nxt.lp_act = 1'b0;
                st_nxt.lp_woken = 1'b0;
            end else if (st_r.lp_act && linkon_s && !force_sel) begin
                // resume stays until software moves the state
                st_nxt.lp_act = 1'b0;
                st_nxt.lp_woken = 1'b1;
            end else if (lp_cond && !st_r.lp_woken) begin
                st_nxt.lp_act = 1'b1;
            end else if (!lp_cond && !force_sel) begin
                st_nxt.lp_act = 1'b0; // repeater keeps running
            end
        end

        // ----------------------------------------
        // card functions power-management control/status
        // ----------------------------------------
        if (wr_crd_pm) begin
            st_nxt.crd_ps = pps_pm_t'(cfg_wdata[PPS_PS_LSB +: 2]);
            st_nxt.crd_pme_en = cfg_wdata[PPS_PME_EN_BIT];
            if (cfg_wdata[PPS_PME_STS_BIT]) begin
                st_nxt.crd_pme_sts = 1'b0;
            end
            // self reset on the way back from D3
            st_nxt.crd_rst = st_r.crd_ps == PPS_D3 && cfg_wdata[PPS_PS_LSB +: 2] == PPS_D0;
        end
        // sampled on ref_clk; a fully clockless D3cold wake needs an async latch
        if (det_chg && st_r.crd_ps != PPS_D0) begin
            st_nxt.crd_pme_sts = 1'b1;
        end

        // ----------------------------------------
        // host bus reset clears all but armed pme context
        // ----------------------------------------
        st_nxt.lnk_keep = 1'b0;
        st_nxt.crd_keep = 1'b0;
        if (pci_rst) begin
            st_nxt.lnk_ps = PPS_D0;
            st_nxt.crd_ps = PPS_D0;
            st_nxt.phy_ctl = PPS_PHY_CTL_RST;
            st_nxt.lp_act = 1'b0;
            st_nxt.lp_woken = 1'b0;
            st_nxt.lnk_keep = keep_lnk_ctx;
            st_nxt.crd_keep = keep_crd_ctx;
            if (!keep_lnk_ctx) begin
                st_nxt.lnk_pme_en = 1'b0;
                st_nxt.lnk_pme_sts = 1'b0;
            end
            if (!keep_crd_ctx) begin
                st_nxt.crd_pme_en = 1'b0;
                st_nxt.crd_pme_sts = 1'b0;
            end
        end

        // ----------------------------------------
        // card clocks run in D0..D2, forced low in D3
        // ----------------------------------------
        // follows the next state so no clock edge escapes on the first D3 cycle
        if (st_nxt.crd_ps == PPS_D3) begin
            st_nxt.cka = 1'b0;
            st_nxt.ckb = 1'b0;
        end else begin
            st_nxt.cka = !st_r.cka;
            st_nxt.ckb = !st_r.ckb;
        end

        // ----------------------------------------
        // interrupts only in D0, otherwise pme alone
        // ----------------------------------------
        st_nxt.int_q = lnk_d0 && link_irq;
        st_nxt.pme_q = (st_r.lnk_pme_en && st_r.lnk_pme_sts)
                     || (st_r.crd_pme_en && st_r.crd_pme_sts);
        // doze and sleep outputs
        st_nxt.doze_q = st_r.lp_act;
        st_nxt.sleep_q = st_r.lp_act && sleep_sel;

        // ----------------------------------------
        // read data, unmapped offsets read zero
        // ----------------------------------------
        st_nxt.rdata = PPS_RDATA_RST;
        if (cfg_rd) begin
            if (!cfg_func && cfg_addr == PPS_LNK_PMCSR_OFS) begin
                st_nxt.rdata[PPS_PS_LSB +: 2] = st_r.lnk_ps;
                st_nxt.rdata[PPS_PME_EN_BIT] = st_r.lnk_pme_en;
                st_nxt.rdata[PPS_PME_STS_BIT] = st_r.lnk_pme_sts;
            end else if (!cfg_func && cfg_addr == PPS_PHY_LP_OFS) begin
                st_nxt.rdata[PPS_PHY_CTL_W-1:0] = st_r.phy_ctl;
            end else if (cfg_func && cfg_addr == PPS_CRD_PMCSR_OFS) begin
                st_nxt.rdata[PPS_PS_LSB +: 2] = st_r.crd_ps;
                st_nxt.rdata[PPS_PME_EN_BIT] = st_r.crd_pme_en;
                st_nxt.rdata[PPS_PME_STS_BIT] = st_r.crd_pme_sts;
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_r <= '{
                lnk_ps: PPS_D0,
                crd_ps: PPS_D0,
                phy_ctl: PPS_PHY_CTL_RST,
                rdata: PPS_RDATA_RST,
                default: '0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign cfg_rdata = st_r.rdata;
    assign host_int = st_r.int_q;
    // open drain: drive low only while requesting wake
    assign pme_n_o = 1'b0;
    assign pme_oe_n = !st_r.pme_q;
    assign ack_tardy_en = lnk_d1;
    assign link_power_status = !lp_state;
    // link registers survive D1, lost in D2/D3
    assign link_regs_clear = lp_state || st_r.lnk_rst;
    // unique id and pme context are never cleared here
    assign link_cfg_clear = lnk_d3;
    assign link_soft_rst = st_r.lnk_rst;
    assign phy_doze = st_r.doze_q;
    assign phy_sleep = st_r.sleep_q;
    assign card_access_en = st_r.crd_ps == PPS_D0;
    assign card_soft_rst = st_r.crd_rst;
    assign card_a_clock_out = st_r.cka;
    assign card_b_clock_out = st_r.ckb;
endmodule
`default_nettype wire

//--- rtl/pps_pkg.sv
package pps_pkg;
    typedef enum logic [1:0] {
        PPS_D0 = 2'h0,
        PPS_D1 = 2'h1,
        PPS_D2 = 2'h2,
        PPS_D3 = 2'h3
    } pps_pm_t;

    // ----------------------------------------
    // config space offsets
    // ----------------------------------------
    localparam logic [7:0] PPS_LNK_PMCSR_OFS = 8'hE0;
    localparam logic [7:0] PPS_PHY_LP_OFS = 8'h98;
    localparam logic [7:0] PPS_CRD_PMCSR_OFS = 8'h84;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int PPS_PS_LSB = 0;
    localparam int PPS_PME_EN_BIT = 8;
    localparam int PPS_PME_STS_BIT = 15;
    localparam int PPS_D2_SLEEP_BIT = 0;
    localparam int PPS_D3_SLEEP_BIT = 1;
    localparam int PPS_D2_FORCE_BIT = 2;
    localparam int PPS_D3_FORCE_BIT = 3;
    localparam int PPS_PHY_CTL_W = 4;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [3:0] PPS_PHY_CTL_RST = 4'h0;
    localparam logic [31:0] PPS_RDATA_RST = 32'h0000_0000;
    localparam int PPS_SYNC_STAGES = 2;
endpackage

//--- rtl/pps_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pps_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pps_sync_st_t;

    pps_sync_st_t st_r;
    pps_sync_st_t st_nxt;

    // first stage feeds only the second one
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_r <= {RST_VAL, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.s2;
endmodule
`default_nettype wire

//--- sim/pps_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pps_ctrl_asserts (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cfg_wr,
    input wire logic cfg_func,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic link_irq,
    input wire logic host_bus_reset_in_n,
    input wire logic host_int,
    input wire logic ack_tardy_en,
    input wire logic link_power_status,
    input wire logic link_regs_clear,
    input wire logic link_cfg_clear,
    input wire logic link_soft_rst,
    input wire logic phy_doze,
    input wire logic phy_sleep,
    input wire logic card_access_en,
    input wire logic card_a_clock_out,
    input wire logic card_b_clock_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic lw;
    logic cw;
    logic d0_irq;
    assign lw = cfg_wr && !cfg_func && cfg_addr == 8'hE0;
    assign cw = cfg_wr && cfg_func && cfg_addr == 8'h84;
    assign d0_irq = link_irq && link_power_status && !ack_tardy_en;
    property p_d1; lw && cfg_wdata[1:0] == 2'h1 |=> ack_tardy_en && link_power_status; endproperty
    a_d1: assert property (p_d1) else $error("d1 entry outputs wrong");
    property p_lps; lw && cfg_wdata[1] |=> !link_power_status && link_regs_clear; endproperty
    a_lps: assert property (p_lps) else $error("link power status kept in d2/d3");
    property p_d3; lw && cfg_wdata[1:0] == 2'h3 |=> link_cfg_clear; endproperty
    a_d3: assert property (p_d3) else $error("d3 clear missing");
    property p_int; host_int == ($past(d0_irq) && $past(resetn)); endproperty
    a_int: assert property (p_int) else $error("host int not tied to d0 irq");
    property p_lrst;
        lw && cfg_wdata[1:0] == 2'h0 && link_cfg_clear |=> link_soft_rst ##1 !link_soft_rst;
    endproperty
    a_lrst: assert property (p_lrst) else $error("link soft reset pulse wrong");
    property p_cd3;
        cw && cfg_wdata[1:0] == 2'h3 |=> (!card_a_clock_out && !card_b_clock_out && !card_access_en)[*2];
    endproperty
    a_cd3: assert property (p_cd3) else $error("card clocks not stopped");
    property p_crun;
        cw && cfg_wdata[1:0] inside {2'h1, 2'h2} |=> !card_access_en
            ##1 ($changed(card_a_clock_out) && $changed(card_b_clock_out));
    endproperty
    a_crun: assert property (p_crun) else $error("card clocks stalled in d1/d2");
    // host bus reset also moves the state, seen two cycles after the pin
    property p_stay;
        !cfg_wr && $past(host_bus_reset_in_n, 2)
            |=> $stable(link_power_status) && $stable(ack_tardy_en);
    endproperty
    a_stay: assert property (p_stay) else $error("state moved without write");
    property p_lp; (phy_doze || phy_sleep) |-> !$past(link_power_status); endproperty
    a_lp: assert property (p_lp) else $error("phy low power outside d2/d3");
endmodule
bind pps_ctrl pps_ctrl_asserts u_chk (.ref_clk(ref_clk), .resetn(resetn), .cfg_wr(cfg_wr),
    .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .link_irq(link_irq),
    .host_bus_reset_in_n(host_bus_reset_in_n),
    .host_int(host_int), .ack_tardy_en(ack_tardy_en), .link_power_status(link_power_status),
    .link_regs_clear(link_regs_clear), .link_cfg_clear(link_cfg_clear),
    .link_soft_rst(link_soft_rst), .phy_doze(phy_doze), .phy_sleep(phy_sleep),
    .card_access_en(card_access_en), .card_a_clock_out(card_a_clock_out),
    .card_b_clock_out(card_b_clock_out));
`default_nettype wire

//--- sim/pps_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pps_ctrl_tb_top import pps_pkg::*;;
    logic ref_clk = 0, resetn = 0, cfg_wr = 0, cfg_rd = 0, cfg_func = 0, link_irq = 0;
    logic lk_req = 0, int_req = 0, idle_req = 0, lp, host_bus_reset_in_n = 1;
    logic pme_n_o, link_soft_rst, card_soft_rst;
    logic [7:0] cfg_addr = 8'h00;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata, r;
    logic [2:0] card_detect = 3'h0;
    logic host_int, pme_oe_n, ack_tardy_en, link_power_status, link_regs_clear, link_cfg_clear;
    logic phy_doze, phy_sleep, card_access_en, phy_linkon, phy_int, ports_idle, sclk_run;
    int error_cnt = 0, n_compared = 0, cyc = 0, phy = 0, s, k, lrst_n = 0, crst_n = 0;
    int st[2] = '{0, 0}, en[2] = '{0, 0}, sts[2] = '{0, 0};
    assign lp = phy_doze | phy_sleep;
    always #5 ref_clk = ~ref_clk;
    pps_ctrl uut (.*, .card_a_clock_out(), .card_b_clock_out());
    pps_phy_model u_phy (.*);
    // ----------------------------------------
    // bus tasks and reference model
    // ----------------------------------------
    function automatic logic [7:0] ofs(input int f);
        return f ? PPS_CRD_PMCSR_OFS : PPS_LNK_PMCSR_OFS;
    endfunction
    function automatic logic [31:0] exp_rd(input int f, input logic [7:0] a);
        if (a == ofs(f)) return 32'((sts[f] << 15) | (en[f] << 8) | st[f]);
        if (f == 0 && a == PPS_PHY_LP_OFS) return 32'(phy);
        return 32'h0;
    endfunction
    function automatic logic pme_exp();
        return !((sts[0] && en[0]) || (sts[1] && en[1]));
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input int f, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cfg_wr <= 1'b1;
        cfg_func <= 1'(f);
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
        if (a == ofs(f)) begin
            st[f] = d[1:0];
            en[f] = d[8];
            if (d[15]) sts[f] = 0;
        end else if (f == 0 && a == PPS_PHY_LP_OFS) begin
            phy = d[3:0];
        end
    endtask
    task automatic rdchk(input int f, input logic [7:0] a);
        @(posedge ref_clk);
        cfg_rd <= 1'b1;
        cfg_func <= 1'(f);
        cfg_addr <= a;
        @(posedge ref_clk);
        cfg_rd <= 1'b0;
        #1;
        chk("cfg_rdata", exp_rd(f, a), cfg_rdata);
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (link_soft_rst) lrst_n++;
        if (card_soft_rst) crst_n++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        r = $urandom(32'h33ecea6f);
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        tick(2);
        chk("pme_oe_n", 1'b1, pme_oe_n);
        chk("pme_n_o", 1'b0, pme_n_o);
        rdchk(0, PPS_LNK_PMCSR_OFS);
        rdchk(1, PPS_CRD_PMCSR_OFS);
        rdchk(0, PPS_PHY_LP_OFS);
        r = $urandom;
        wr(0, 8'h10, r);
        rdchk(0, 8'h10);
        wr(0, PPS_PHY_LP_OFS, {28'h0, r[3:0]});
        rdchk(0, PPS_PHY_LP_OFS);
        link_irq <= 1'b1;
        // no transmit context, no bus manager role, ack_tardy event clear
        for (s = 0; s < 4; s++) begin
            wr(0, PPS_LNK_PMCSR_OFS, 32'(s));
            if (s == 1) sts[0] = 1;
            tick(2);
            chk("ack_tardy_en", s == 1, ack_tardy_en);
            chk("link_power_status", s < 2, link_power_status);
            chk("sclk_run", s < 2, sclk_run);
            chk("link_regs_clear", s > 1, link_regs_clear);
            chk("link_cfg_clear", s == 3, link_cfg_clear);
            chk("host_int", s == 0, host_int);
        end
        chk("pme_oe_n", pme_exp(), pme_oe_n);
        rdchk(0, PPS_LNK_PMCSR_OFS);
        wr(0, PPS_LNK_PMCSR_OFS, 32'h8000);
        link_irq <= 1'b0;
        rdchk(0, PPS_LNK_PMCSR_OFS);
        chk("link_soft_rst", 1, lrst_n);
        for (s = 0; s < 4; s++) begin
            wr(1, PPS_CRD_PMCSR_OFS, 32'(s));
            tick(2);
            chk("card_access_en", s == 0, card_access_en);
        end
        wr(1, PPS_CRD_PMCSR_OFS, 32'h0);
        tick(2);
        chk("card_soft_rst", 1, crst_n);
        // non-forced doze/sleep in d2, woken by linkon or phy interrupt
        r = $urandom;
        wr(0, PPS_PHY_LP_OFS, {30'h0, r[1:0]});
        idle_req <= 1'b1;
        wr(0, PPS_LNK_PMCSR_OFS, 32'h0102);
        tick(5);
        chk("phy_low_power", 1'b1, lp);
        chk("phy_sleep", r[0], phy_sleep);
        if (r[2]) lk_req <= 1'b1;
        else int_req <= 1'b1;
        @(posedge ref_clk);
        lk_req <= 1'b0;
        int_req <= 1'b0;
        sts[0] = 1;
        tick(7);
        chk("pme_oe_n", pme_exp(), pme_oe_n);
        chk("phy_low_power", !r[2], lp);
        rdchk(0, PPS_LNK_PMCSR_OFS);
        wr(0, PPS_LNK_PMCSR_OFS, 32'h8102);
        tick(3);
        chk("pme_oe_n", pme_exp(), pme_oe_n);
        @(posedge ref_clk);
        idle_req <= 1'b0;
        tick(5);
        chk("phy_low_power", 1'b0, lp);
        // forced low power in d3: no linkon resume, no wake
        wr(0, PPS_PHY_LP_OFS, {28'h0, 2'b10, r[1:0]});
        wr(0, PPS_LNK_PMCSR_OFS, 32'h0103);
        tick(5);
        chk("phy_low_power", 1'b1, lp);
        chk("phy_sleep", r[1], phy_sleep);
        lk_req <= 1'b1;
        @(posedge ref_clk);
        lk_req <= 1'b0;
        tick(7);
        chk("pme_oe_n", 1'b1, pme_oe_n);
        chk("phy_low_power", 1'b1, lp);
        wr(0, PPS_LNK_PMCSR_OFS, 32'h0100);
        tick(3);
        chk("phy_low_power", 1'b0, lp);
        chk("link_power_status", 1'b1, link_power_status);
        chk("link_soft_rst", 2, lrst_n);
        // card d3: detect change on a random slot raises wake
        wr(1, PPS_CRD_PMCSR_OFS, 32'h0103);
        k = $urandom_range(2);
        card_detect[k] <= ~card_detect[k];
        sts[1] = 1;
        tick(7);
        chk("pme_oe_n", pme_exp(), pme_oe_n);
        rdchk(1, PPS_CRD_PMCSR_OFS);
        wr(1, PPS_CRD_PMCSR_OFS, 32'h8000);
        tick(3);
        chk("pme_oe_n", pme_exp(), pme_oe_n);
        rdchk(1, PPS_CRD_PMCSR_OFS);
        chk("card_soft_rst", 2, crst_n);
        // host bus reset: armed link d3 context kept, the rest back to d0
        wr(0, PPS_LNK_PMCSR_OFS, 32'h0103);
        wr(1, PPS_CRD_PMCSR_OFS, 32'h0102);
        host_bus_reset_in_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        host_bus_reset_in_n <= 1'b1;
        st = '{0, 0};
        en[1] = 0;
        phy = 0;
        tick(4);
        rdchk(0, PPS_LNK_PMCSR_OFS);
        rdchk(1, PPS_CRD_PMCSR_OFS);
        rdchk(0, PPS_PHY_LP_OFS);
        chk("link_power_status", 1'b1, link_power_status);
        finish_test();
    end
endmodule
`default_nettype wire

//--- sim/pps_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module pps_phy_model (
    input wire logic ref_clk,
    input wire logic link_power_status,
    input wire logic lk_req,
    input wire logic int_req,
    input wire logic idle_req,
    output logic phy_linkon,
    output logic phy_int,
    output logic ports_idle,
    output logic sclk_run
);
    // ----------------------------------------
    // phy side: short wake pulses, port state
    // ----------------------------------------
    logic [1:0] lk_cnt = 2'h0;
    logic [1:0] int_cnt = 2'h0;
    always @(posedge ref_clk) begin
        lk_cnt <= lk_req ? 2'h3 : lk_cnt - {1'b0, lk_cnt != 2'h0};
        int_cnt <= int_req ? 2'h3 : int_cnt - {1'b0, int_cnt != 2'h0};
    end
    assign phy_linkon = lk_cnt != 2'h0;
    assign phy_int = int_cnt != 2'h0;
    assign ports_idle = idle_req;
    // link clock only while link asks for it
    assign sclk_run = link_power_status;
endmodule
`default_nettype wire
